/* rtl/pmr_regs.svh */
// Register offsets, field positions, reset values and scaling shifts of the monitor
`ifndef PMR_REGS_SVH
`define PMR_REGS_SVH

`define PMR_OFS_CONFIG        8'h00
`define PMR_OFS_SHUNT_CAL     8'h02
`define PMR_OFS_SHUNT_RES     8'h04
`define PMR_OFS_BUS_RES       8'h05
`define PMR_OFS_DIE_TEMP      8'h06
`define PMR_OFS_CURRENT       8'h07
`define PMR_OFS_POWER         8'h08
`define PMR_OFS_ENERGY        8'h09
`define PMR_OFS_CHARGE        8'h0a
`define PMR_OFS_PWR_LIMIT     8'h11
`define PMR_OFS_MAKER_ID      8'h3e
`define PMR_OFS_PART_ID       8'h3f

`define PMR_CFG_ACC_CLEAR_BIT 14
`define PMR_CFG_RANGE_BIT     4
`define PMR_CONFIG_RESET      16'h0000
`define PMR_SHUNT_CAL_RESET   15'h1000
`define PMR_PWR_LIMIT_RESET   16'hffff

`define PMR_LEN_16            3'h2
`define PMR_LEN_24            3'h3
`define PMR_LEN_40            3'h5

`define PMR_CUR_LO            15
`define PMR_PWR_LO            14
`define PMR_I2C_ADDR_RESET    7'h40

`endif

/* rtl/pmr_pkg.sv */
// Types shared by the monitor register block and its serial slave
`default_nettype none
package pmr_pkg;

  typedef enum logic [3:0] {
    PMR_IDLE  = 4'h0,
    PMR_ADDR  = 4'h1,
    PMR_ACK_A = 4'h2,
    PMR_PTR   = 4'h3,
    PMR_ACK_P = 4'h4,
    PMR_WR    = 4'h5,
    PMR_ACK_W = 4'h6,
    PMR_RD    = 4'h7,
    PMR_RACK  = 4'h8
  } pmr_i2c_e;

  typedef struct packed {
    logic        scl_q;
    logic        sda_q;
    pmr_i2c_e    st;
    logic [3:0]  bitc;
    logic [7:0]  shreg;
    logic [7:0]  ptr;
    logic [7:0]  hi;
    logic [2:0]  bytec;
    logic [2:0]  nbytes;
    logic        rw;
    logic        nack;
    logic        sda_oe;
    logic [39:0] word;
    logic        wr_stb;
    logic [15:0] wr_data;
  } pmr_i2c_s;

  typedef struct packed {
    logic        range_sel;
    logic        acc_clear;
    logic [14:0] shunt_cal;
    logic [15:0] pwr_limit;
    logic [19:0] shunt_res;
    logic [19:0] bus_res;
    logic [15:0] temp;
    logic [19:0] current;
    logic [23:0] power;
    logic [39:0] energy;
    logic [39:0] charge;
    logic        stage1;
    logic        stage2;
    logic        over_power;
  } pmr_top_s;

endpackage
`default_nettype wire

/* rtl/pmr_i2c_slave.sv */
// Serial register slave: address, register pointer, 16-bit writes and multi-byte reads
`default_nettype none
`include "pmr_regs.svh"
module pmr_i2c_slave (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Serial pins
  input  wire logic [6:0]  dev_addr,
  input  wire logic        scl,
  input  wire logic        sda_i,
  output logic             sda_oe,
  // Register side
  output logic [7:0]       ptr,
  input  wire logic [39:0] rd_word,
  input  wire logic [2:0]  rd_len,
  output logic             wr_stb,
  output logic [15:0]      wr_data
);

  pmr_pkg::pmr_i2c_s s_reg;
  pmr_pkg::pmr_i2c_s s_next;

  function automatic logic [7:0] pick(input logic [39:0] w, input logic [2:0] n,
                                      input logic [2:0] k);
    logic [2:0] idx;
    idx = n - k - 3'h1;
    pick = w[idx*8 +: 8];
  endfunction

  logic start_c;
  logic stop_c;
  logic rise_c;
  logic fall_c;
  logic [7:0] nxt_byte;

  assign start_c = s_reg.scl_q & scl & s_reg.sda_q & ~sda_i;
  assign stop_c  = s_reg.scl_q & scl & ~s_reg.sda_q & sda_i;
  assign rise_c  = ~s_reg.scl_q & scl;
  assign fall_c  = s_reg.scl_q & ~scl;
  assign nxt_byte = pick(s_reg.word, s_reg.nbytes, s_reg.bytec);

  always_comb begin
    s_next = s_reg;
    s_next.scl_q = scl;
    s_next.sda_q = sda_i;
    s_next.wr_stb = 1'b0;
    if (start_c) begin
      s_next.st = pmr_pkg::PMR_ADDR;
      s_next.bitc = 4'h0;
      s_next.sda_oe = 1'b0;
      s_next.bytec = 3'h0;
    end else if (stop_c) begin
      s_next.st = pmr_pkg::PMR_IDLE;
      s_next.sda_oe = 1'b0;
    end else begin
      unique case (s_reg.st)
        pmr_pkg::PMR_IDLE: begin
        end
        pmr_pkg::PMR_ADDR, pmr_pkg::PMR_PTR, pmr_pkg::PMR_WR: begin
          if (rise_c) begin
            s_next.shreg = {s_reg.shreg[6:0], sda_i};
            s_next.bitc = s_reg.bitc + 4'h1;
          end
          if (fall_c && s_reg.bitc == 4'h8) begin
            s_next.sda_oe = 1'b1;
            if (s_reg.st == pmr_pkg::PMR_ADDR) begin
              if (s_reg.shreg[7:1] == dev_addr) begin
                s_next.st = pmr_pkg::PMR_ACK_A;
                s_next.rw = s_reg.shreg[0];
                s_next.word = rd_word;
                s_next.nbytes = rd_len;
                s_next.bytec = 3'h0;
              end else begin
                s_next.st = pmr_pkg::PMR_IDLE;
                s_next.sda_oe = 1'b0;
              end
            end else if (s_reg.st == pmr_pkg::PMR_PTR) begin
              s_next.ptr = s_reg.shreg;
              s_next.bytec = 3'h0;
              s_next.st = pmr_pkg::PMR_ACK_P;
            end else begin
              s_next.st = pmr_pkg::PMR_ACK_W;
              if (s_reg.bytec == 3'h0) begin
                s_next.hi = s_reg.shreg;
                s_next.bytec = 3'h1;
              end else begin
                s_next.wr_stb = 1'b1;
                s_next.wr_data = {s_reg.hi, s_reg.shreg};
                s_next.bytec = 3'h0;
              end
            end
          end
        end
        pmr_pkg::PMR_ACK_A, pmr_pkg::PMR_ACK_P, pmr_pkg::PMR_ACK_W: begin
          if (fall_c) begin
            s_next.bitc = 4'h0;
            s_next.sda_oe = 1'b0;
            if (s_reg.st == pmr_pkg::PMR_ACK_A && s_reg.rw) begin
              s_next.st = pmr_pkg::PMR_RD;
              s_next.shreg = nxt_byte;
              s_next.sda_oe = ~nxt_byte[7];
            end else if (s_reg.st == pmr_pkg::PMR_ACK_A) begin
              s_next.st = pmr_pkg::PMR_PTR;
            end else begin
              s_next.st = pmr_pkg::PMR_WR;
            end
          end
        end
        pmr_pkg::PMR_RD: begin
          if (rise_c) begin
            s_next.bitc = s_reg.bitc + 4'h1;
          end
          if (fall_c) begin
            if (s_reg.bitc == 4'h8) begin
              s_next.sda_oe = 1'b0;
              s_next.st = pmr_pkg::PMR_RACK;
              s_next.bytec = (s_reg.bytec + 3'h1 >= s_reg.nbytes) ? 3'h0 : s_reg.bytec + 3'h1;
            end else begin
              s_next.sda_oe = ~s_reg.shreg[3'h7 - s_reg.bitc[2:0]];
            end
          end
        end
        pmr_pkg::PMR_RACK: begin
          if (rise_c) begin
            s_next.nack = sda_i;
          end
          if (fall_c) begin
            if (s_reg.nack) begin
              s_next.st = pmr_pkg::PMR_IDLE;
            end else begin
              s_next.st = pmr_pkg::PMR_RD;
              s_next.bitc = 4'h0;
              s_next.shreg = nxt_byte;
              s_next.sda_oe = ~nxt_byte[7];
            end
          end
        end
        default: begin
          s_next.st = pmr_pkg::PMR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{scl_q: 1'b1, sda_q: 1'b1, st: pmr_pkg::PMR_IDLE, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign sda_oe  = s_reg.sda_oe;
  assign ptr     = s_reg.ptr;
  assign wr_stb  = s_reg.wr_stb;
  assign wr_data = s_reg.wr_data;

endmodule
`default_nettype wire

/* rtl/pmr_monitor.sv */
// Power monitor result, accumulator and identification registers behind a serial slave
// Functional notes
// - Read-only 16-bit maker identifier at 3Eh, fixed, writes ignored.
// - Read-only identifier at 3Fh: part code bits 15-4, revision bits 3-0.
// - Range-select configuration bit chooses wide or narrow shunt input range.
// - Result codes are linear: shunt 312.5/78.125 nV, bus 195.3125 uV per LSB.
// - Shunt and bus results are 20-bit; shunt signed, bus non-negative.
// - Die temperature result is signed 16-bit, 7.8125 millidegrees per LSB.
// - Temperature code spans about minus to plus 256 degrees.
// - Each shunt conversion produces a new current from shunt code and scale.
// - A zero scale factor forces the current result to zero.
// - Power is 24-bit unsigned, LSB equal to 3.2 current LSBs in watts.
// - Energy accumulates in 40-bit unsigned register, adding the unscaled power result once per conversion.
// - Charge accumulates in 40-bit two's complement, following current sign.
// - Energy and charge wrap through zero on overflow, never saturate.
// - Accumulator clear bit zeroes energy and charge at any time.
// - Power limit times 256 is compared with power to flag over-power.
`default_nettype none
`include "pmr_regs.svh"
module pmr_monitor #(
  parameter logic [15:0] MAKER_CODE = 16'h0a5c,  // Arbitrary value
  parameter logic [11:0] PART_CODE  = 12'h0b1,   // Arbitrary value
  parameter logic [3:0]  REV_CODE   = 4'h2       // Arbitrary value
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Serial pins
  input  wire logic [6:0]  dev_addr,
  input  wire logic        scl,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // Converter results
  input  wire logic [19:0] shunt_code,
  input  wire logic        shunt_valid,
  input  wire logic [19:0] bus_code,
  input  wire logic        bus_valid,
  input  wire logic [15:0] temp_code,
  input  wire logic        temp_valid,
  // Status to the rest of the chip
  output logic             input_range_select,
  output logic             power_over_limit
);

  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  pmr_pkg::pmr_top_s s_reg;
  pmr_pkg::pmr_top_s s_next;

  logic [7:0]  ptr;
  logic        wr_stb;
  logic [15:0] wr_data;
  logic [39:0] rd_word;
  logic [2:0]  rd_len;
  logic        sda_oe_c;

  pmr_i2c_slave u_slave (
    .clk     (clk),
    .rst_n   (rst_n),
    .dev_addr(dev_addr),
    .scl     (scl),
    .sda_i   (sda_i),
    .sda_oe  (sda_oe_c),
    .ptr     (ptr),
    .rd_word (rd_word),
    .rd_len  (rd_len),
    .wr_stb  (wr_stb),
    .wr_data (wr_data)
  );

  logic signed [35:0] cur_prod;
  logic [19:0]        cur_mag;
  logic [39:0]        pwr_prod;
  logic [25:0]        pwr_full;

  assign cur_prod = $signed(shunt_code) * $signed({1'b0, s_reg.shunt_cal});
  assign cur_mag  = s_reg.current[19] ? 20'(-s_reg.current) : s_reg.current;
  assign pwr_prod = {20'h0, cur_mag} * {20'h0, s_reg.bus_res};
  assign pwr_full = pwr_prod[`PMR_PWR_LO +: 26];

  // Read data multiplexer
  always_comb begin
    rd_word = 40'h0;
    rd_len  = `PMR_LEN_16;
    unique case (ptr)
      `PMR_OFS_CONFIG: begin
        rd_word[`PMR_CFG_RANGE_BIT] = s_reg.range_sel;
      end
      `PMR_OFS_SHUNT_CAL: begin
        rd_word[14:0] = s_reg.shunt_cal;
      end
      `PMR_OFS_SHUNT_RES: begin
        rd_word[23:0] = {{4{s_reg.shunt_res[19]}}, s_reg.shunt_res};
        rd_len = `PMR_LEN_24;
      end
      `PMR_OFS_BUS_RES: begin
        rd_word[23:0] = {4'h0, s_reg.bus_res};
        rd_len = `PMR_LEN_24;
      end
      `PMR_OFS_DIE_TEMP: begin
        rd_word[15:0] = s_reg.temp;
      end
      `PMR_OFS_CURRENT: begin
        rd_word[23:0] = {{4{s_reg.current[19]}}, s_reg.current};
        rd_len = `PMR_LEN_24;
      end
      `PMR_OFS_POWER: begin
        rd_word[23:0] = s_reg.power;
        rd_len = `PMR_LEN_24;
      end
      `PMR_OFS_ENERGY: begin
        rd_word = s_reg.energy;
        rd_len = `PMR_LEN_40;
      end
      `PMR_OFS_CHARGE: begin
        rd_word = s_reg.charge;
        rd_len = `PMR_LEN_40;
      end
      `PMR_OFS_PWR_LIMIT: begin
        rd_word[15:0] = s_reg.pwr_limit;
      end
      `PMR_OFS_MAKER_ID: begin
        rd_word[15:0] = MAKER_CODE;
      end
      `PMR_OFS_PART_ID: begin
        rd_word[15:0] = {PART_CODE, REV_CODE};
      end
      default: begin
        rd_word = 40'h0;
      end
    endcase
  end

  always_comb begin
    s_next = s_reg;
    s_next.acc_clear = 1'b0;
    s_next.stage1 = 1'b0;
    s_next.stage2 = 1'b0;
    // Register writes; identifiers and results ignore them
    if (wr_stb) begin
      unique case (ptr)
        `PMR_OFS_CONFIG: begin
          s_next.range_sel = wr_data[`PMR_CFG_RANGE_BIT];
          s_next.acc_clear = wr_data[`PMR_CFG_ACC_CLEAR_BIT];
        end
        `PMR_OFS_SHUNT_CAL: begin
          s_next.shunt_cal = wr_data[14:0];
        end
        `PMR_OFS_PWR_LIMIT: begin
          s_next.pwr_limit = wr_data;
        end
        default: begin
        end
      endcase
    end
    if (bus_valid) begin
      s_next.bus_res = bus_code;
    end
    if (temp_valid) begin
      s_next.temp = temp_code;
    end
    if (shunt_valid) begin
      s_next.shunt_res = shunt_code;
      s_next.current = cur_prod[`PMR_CUR_LO +: 20];
      s_next.stage1 = 1'b1;
    end
    if (s_reg.stage1) begin
      s_next.power = (pwr_full[25:24] != 2'b00) ? 24'hffffff : pwr_full[23:0];
      s_next.charge = s_reg.charge + {{20{s_reg.current[19]}}, s_reg.current};
      s_next.stage2 = 1'b1;
    end
    if (s_reg.stage2) begin
      s_next.energy = s_reg.energy + {16'h0, s_reg.power};
    end
    if (s_reg.acc_clear) begin
      s_next.energy = 40'h0;
      s_next.charge = 40'h0;
    end
    s_next.over_power = s_reg.power > {s_reg.pwr_limit, 8'h00};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{range_sel: 1'(`PMR_CONFIG_RESET >> `PMR_CFG_RANGE_BIT),
                 shunt_cal: `PMR_SHUNT_CAL_RESET,
                 pwr_limit: `PMR_PWR_LIMIT_RESET,
                 default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign input_range_select = s_reg.range_sel;
  assign power_over_limit   = s_reg.over_power;
  assign sda_oe             = sda_oe_c;
  assign sda_o              = 1'b0;

endmodule
`default_nettype wire

/* testbench/pmr_monitor_checker.sv */
// Pin-level assertions for the monitor register block
`default_nettype none
module pmr_monitor_checker (
  // Watched pins
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic shunt_valid,
  input wire logic input_range_select,
  input wire logic power_over_limit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [7:0] oe_cnt_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      oe_cnt_reg <= 8'h00;
    else
      oe_cnt_reg <= sda_oe ? oe_cnt_reg + 8'h01 : 8'h00;
  end
  a_sda_o_low: assert property (sda_o == 1'b0)
    else $error("data value not low");
  a_reset_quiet: assert property ($rose(rstn) |->
    (!sda_oe && !power_over_limit && !input_range_select)[*3])
    else $error("outputs active after reset");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl)
    else $error("data drive moved while clock high");
  a_oe_hold_high: assert property ($rose(scl) |=> $stable(sda_oe)[*3])
    else $error("data drive unstable in high phase");
  a_oe_full_bit: assert property ($rose(sda_oe) |-> sda_oe[*6])
    else $error("data drive too short");
  a_oe_released: assert property (oe_cnt_reg <= 8'h4c)
    else $error("data line held too long");
  a_range_on_write: assert property ($changed(input_range_select) |->
    sda_oe || $past(sda_oe) || $past(sda_oe, 2) || $past(sda_oe, 3))
    else $error("range changed without a write");
  a_limit_cause: assert property ($changed(power_over_limit) |->
    $past(shunt_valid, 3) || sda_oe || $past(sda_oe) || $past(sda_oe, 2)
    || $past(sda_oe, 3))
    else $error("over-power flag moved without cause");
endmodule
bind pmr_monitor pmr_monitor_checker chk (
  .clk(clk), .rstn(rstn), .scl(scl), .sda_o(sda_o), .sda_oe(sda_oe),
  .shunt_valid(shunt_valid), .input_range_select(input_range_select),
  .power_over_limit(power_over_limit)
);
`default_nettype wire

/* testbench/pmr_host_model.sv */
// Serial host model driving clock and open-drain data
`default_nettype none
module pmr_host_model (
  // Clock
  input  wire logic        clk,
  // Serial lines
  input  wire logic        sda,
  output logic             scl,
  output logic             sda_low,
  // Read results
  output logic             rd_done,
  output logic [39:0]      rd_data,
  output logic             last_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    rd_done = 1'b0;
    rd_data = 40'h0;
    last_ack = 1'b0;
  end
  // Each level held four cycles, data moves one cycle after the clock
  task automatic hold(input logic c, input logic d);
    @(posedge clk);
    scl <= c;
    @(posedge clk);
    sda_low <= ~d;
    repeat (2) @(posedge clk);
  endtask
  task automatic put(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      hold(1'b0, b[i]);
      hold(1'b1, b[i]);
    end
    hold(1'b0, 1'b1);
    hold(1'b1, 1'b1);
    last_ack = sda;
  endtask
  task automatic get(input logic last, output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      hold(1'b0, 1'b1);
      hold(1'b1, 1'b1);
      b = {b[6:0], sda};
    end
    hold(1'b0, last);
    hold(1'b1, last);
  endtask
  task automatic stop();
    hold(1'b0, 1'b0);
    hold(1'b1, 1'b0);
    hold(1'b1, 1'b1);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d);
    hold(1'b1, 1'b0);
    put({a, 1'b0});
    put(p);
    put(d[15:8]);
    put(d[7:0]);
    stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] p, input logic [2:0] n);
    logic [7:0]  b;
    logic [39:0] acc;
    acc = 40'h0;
    hold(1'b1, 1'b0);
    put({a, 1'b0});
    put(p);
    hold(1'b0, 1'b1);
    hold(1'b1, 1'b1);
    hold(1'b1, 1'b0);
    put({a, 1'b1});
    for (int i = 0; i < n; i++) begin
      get(i == n - 1, b);
      acc = {acc[31:0], b};
    end
    stop();
    // Result published with its strobe so the checker never races a new read
    @(posedge clk);
    rd_data <= acc;
    rd_done <= 1'b1;
    @(posedge clk);
    rd_done <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* testbench/pmr_monitor_bench.sv */
// Self-checking bench for the monitor register block
`default_nettype none
`include "pmr_regs.svh"
module pmr_monitor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0]  ADDR  = 7'h45;
  localparam logic [15:0] MAKER = 16'h3c5a;  // Arbitrary value
  localparam logic [11:0] PART  = 12'h7d2;   // Arbitrary value
  localparam logic [3:0]  REV   = 4'h9;      // Arbitrary value
  logic        clk = 1'b0, rstn = 1'b0;
  logic [19:0] shunt_code = 20'h0, bus_code = 20'h0;
  logic [15:0] temp_code = 16'h0;
  logic        shunt_valid = 1'b0, bus_valid = 1'b0, temp_valid = 1'b0;
  logic        scl, sda_low, sda_o, sda_oe, rd_done, last_ack;
  logic        input_range_select, power_over_limit;
  logic [39:0] rd_data, en = 40'h0, ch = 40'h0;
  logic [39:0] exp_q[$];
  logic [14:0] cal = 15'h1000;
  logic [15:0] lim = 16'hffff;
  logic [19:0] cur;
  logic [23:0] pw;
  int          fail_count = 0, checks = 0;
  wire logic   sda_line = !(sda_low || (sda_oe && !sda_o));
  always #2.5 clk = ~clk;
  pmr_monitor #(.MAKER_CODE(MAKER), .PART_CODE(PART), .REV_CODE(REV)) uut (
    .clk(clk), .rstn(rstn), .dev_addr(ADDR), .scl(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .shunt_code(shunt_code),
    .shunt_valid(shunt_valid), .bus_code(bus_code), .bus_valid(bus_valid),
    .temp_code(temp_code), .temp_valid(temp_valid),
    .input_range_select(input_range_select), .power_over_limit(power_over_limit)
  );
  pmr_host_model host (
    .clk(clk), .sda(sda_line), .scl(scl), .sda_low(sda_low),
    .rd_done(rd_done), .rd_data(rd_data), .last_ack(last_ack)
  );
  task automatic conclude();
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cmp_rd(input logic [39:0] e, input logic [39:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic cmp_pin(input logic e, input logic g);
    cmp_rd({39'h0, e}, {39'h0, g});
  endtask
  always @(posedge clk) begin
    if (rd_done === 1'b1)
      cmp_rd(exp_q.pop_front(), rd_data);
  end
  task automatic rd(input logic [7:0] p, input logic [2:0] n, input logic [39:0] e);
    exp_q.push_back(e);
    host.rd(ADDR, p, n);
  endtask
  task automatic convert(input logic [19:0] sh, input logic [19:0] vb, input logic [15:0] t);
    logic signed [39:0] prod;
    logic [19:0]        mag;
    logic [39:0]        pp;
    @(posedge clk);
    bus_code <= vb;
    bus_valid <= 1'b1;
    temp_code <= t;
    temp_valid <= 1'b1;
    @(posedge clk);
    bus_valid <= 1'b0;
    temp_valid <= 1'b0;
    shunt_code <= sh;
    shunt_valid <= 1'b1;
    @(posedge clk);
    shunt_valid <= 1'b0;
    repeat (4) @(posedge clk);
    prod = $signed(sh) * $signed({1'b0, cal});
    cur = prod[34:15];
    mag = cur[19] ? (~cur + 20'h1) : cur;
    pp = ({20'h0, mag} * {20'h0, vb}) >> 14;
    pw = (pp > 40'hffffff) ? 24'hffffff : pp[23:0];
    ch = ch + {{20{cur[19]}}, cur};
    en = en + {16'h0, pw};
    rd(`PMR_OFS_SHUNT_RES, `PMR_LEN_24, {16'h0, {4{sh[19]}}, sh});
    rd(`PMR_OFS_BUS_RES, `PMR_LEN_24, {20'h0, vb});
    rd(`PMR_OFS_DIE_TEMP, `PMR_LEN_16, {24'h0, t});
    rd(`PMR_OFS_CURRENT, `PMR_LEN_24, {16'h0, {4{cur[19]}}, cur});
    rd(`PMR_OFS_POWER, `PMR_LEN_24, {16'h0, pw});
    rd(`PMR_OFS_ENERGY, `PMR_LEN_40, en);
    rd(`PMR_OFS_CHARGE, `PMR_LEN_40, ch);
    cmp_pin({8'h0, pw} > {8'h0, lim, 8'h0}, power_over_limit);
  endtask
  initial begin
    repeat (95000) @(posedge clk);
    fail_count++;
    conclude();
  end
  initial begin
    void'($urandom(72609));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`PMR_OFS_MAKER_ID, `PMR_LEN_16, {24'h0, MAKER});
    rd(`PMR_OFS_PART_ID, `PMR_LEN_16, {24'h0, PART, REV});
    host.wr(ADDR, `PMR_OFS_MAKER_ID, ~MAKER);
    rd(`PMR_OFS_MAKER_ID, `PMR_LEN_16, {24'h0, MAKER});
    rd(`PMR_OFS_SHUNT_CAL, `PMR_LEN_16, {25'h0, `PMR_SHUNT_CAL_RESET});
    rd(`PMR_OFS_PWR_LIMIT, `PMR_LEN_16, {24'h0, `PMR_PWR_LIMIT_RESET});
    rd(8'h20, `PMR_LEN_16, 40'h0);
    host.wr(ADDR ^ 7'h01, `PMR_OFS_CONFIG, 16'h0010);
    cmp_pin(1'b1, last_ack);
    cmp_pin(1'b0, input_range_select);
    // range bit sets the pin and reads back alone
    host.wr(ADDR, `PMR_OFS_CONFIG, 16'h1 << `PMR_CFG_RANGE_BIT);
    cmp_pin(1'b1, input_range_select);
    rd(`PMR_OFS_CONFIG, `PMR_LEN_16, 40'h10);
    for (int i = 0; i < 6; i++) begin
      // scale factor times four in narrow range
      cal = 15'($urandom_range(1023, 1)) << 2;
      host.wr(ADDR, `PMR_OFS_SHUNT_CAL, {1'b0, cal});
      convert(i == 0 ? 20'h80000 : 20'($urandom), 20'($urandom),
              i == 0 ? 16'h8000 : 16'($urandom));
    end
    cal = 15'h0;
    host.wr(ADDR, `PMR_OFS_SHUNT_CAL, 16'h0);
    convert(20'h12345, 20'h00100, 16'h0100);
    // flag rises and falls around the threshold
    lim = 16'h0001;
    host.wr(ADDR, `PMR_OFS_PWR_LIMIT, lim);
    cal = 15'h1000;
    host.wr(ADDR, `PMR_OFS_SHUNT_CAL, {1'b0, cal});
    convert(20'h40000, 20'h10000, 16'h0000);
    convert(20'h00000, 20'h10000, 16'h0000);
    // writing zero keeps totals, clear bit zeroes them
    host.wr(ADDR, `PMR_OFS_CONFIG, 16'h0000);
    cmp_pin(1'b0, input_range_select);
    rd(`PMR_OFS_ENERGY, `PMR_LEN_40, en);
    host.wr(ADDR, `PMR_OFS_CONFIG, 16'h1 << `PMR_CFG_ACC_CLEAR_BIT);
    en = 40'h0;
    ch = 40'h0;
    rd(`PMR_OFS_ENERGY, `PMR_LEN_40, en);
    rd(`PMR_OFS_CHARGE, `PMR_LEN_40, ch);
    convert(20'hfff00, 20'h08000, 16'h0000);
    // Let the last read reach the compare process; unread notes are mismatches
    repeat (2) @(posedge clk);
    if (exp_q.size() != 0)
      fail_count++;
    conclude();
  end
endmodule
`default_nettype wire
